// ===== common/tcom_params.svh
`ifndef TCOM_PARAMS_SVH
`define TCOM_PARAMS_SVH
`define TCOM_ADDR_W 8
`define TCOM_IDX_W 6
`define TCOM_CTRL_A_IDX 6'h2f
`define TCOM_MODE_HI_IDX 6'h30
`define TCOM_CMP_A_IDX 6'h31
`define TCOM_CMP_B_IDX 6'h32
`define TCOM_STATUS_IDX 6'h33
`define TCOM_CODE_OFF 2'h0
`define TCOM_CODE_TOGGLE 2'h1
`define TCOM_CODE_CLEAR 2'h2
`define TCOM_CODE_SET 2'h3
`define TCOM_MAX 8'hff
`define TCOM_RESP_OKAY 2'h0
`define TCOM_RESP_SLVERR 2'h2
`endif

// ===== common/tcom_pkg.sv
`default_nettype none
package tcom_pkg;
    typedef enum {
        TCOM_NORMAL,
        TCOM_CTC,
        TCOM_PHASE_MAX,
        TCOM_PHASE_CMP,
        TCOM_FAST_MAX,
        TCOM_FAST_CMP,
        TCOM_RSVD
    } tcom_wave_t;

    function automatic tcom_wave_t tcom_decode(input logic [2:0] sel);
        case (sel)
            3'h0: return TCOM_NORMAL;
            3'h1: return TCOM_PHASE_MAX;
            3'h2: return TCOM_CTC;
            3'h3: return TCOM_FAST_MAX;
            3'h5: return TCOM_PHASE_CMP;
            3'h7: return TCOM_FAST_CMP;
            default: return TCOM_RSVD;
        endcase
    endfunction
endpackage
`default_nettype wire

// ===== common/tcom_ifs.sv
`default_nettype none
interface tcom_chan_if;
    logic [1:0] code;
    tcom_pkg::tcom_wave_t kind;
    logic mode_bit2;
    logic [7:0] cmp;
    logic [7:0] top;
    logic [7:0] count;
    logic tick;
    logic down;
    logic wave;
    logic conn;
    modport ctrl(output code, kind, mode_bit2, cmp, top, count, tick, down, input wave, conn);
    modport chan(input code, kind, mode_bit2, cmp, top, count, tick, down, output wave, conn);
endinterface

interface tcom_reg_if;
    logic wr_en;
    logic [5:0] wr_idx;
    logic [7:0] wr_data;
    logic wr_hit;
    logic [5:0] rd_idx;
    logic [7:0] rd_data;
    logic rd_hit;
    modport slave(output wr_en, wr_idx, wr_data, rd_idx, input wr_hit, rd_data, rd_hit);
    modport regs(input wr_en, wr_idx, wr_data, rd_idx, output wr_hit, rd_data, rd_hit);
endinterface
`default_nettype wire

// ===== logic/tcom_wave_chan.sv
`include "tcom_params.svh"
`default_nettype none
module tcom_wave_chan #(
    parameter bit IS_A = 1'b1
) (
    input wire logic clk,
    input wire logic rst_n,
    tcom_chan_if.chan ch
);
    logic wave_reg, wave_next, conn_reg, conn_next;
    logic match, at_top, fast, pwm, cmp_is_top;

    always_comb begin
        match = ch.tick && (ch.count == ch.cmp);
        at_top = ch.tick && (ch.count == ch.top);
        fast = (ch.kind == tcom_pkg::TCOM_FAST_MAX) || (ch.kind == tcom_pkg::TCOM_FAST_CMP);
        pwm = fast || (ch.kind == tcom_pkg::TCOM_PHASE_MAX) || (ch.kind == tcom_pkg::TCOM_PHASE_CMP);
        cmp_is_top = ch.cmp == ch.top;
        wave_next = wave_reg;
        // channel a toggle in pwm needs the third mode bit, otherwise the pin is released
        conn_next = (ch.code != `TCOM_CODE_OFF) &&
                    !(pwm && ch.code == `TCOM_CODE_TOGGLE && IS_A && !ch.mode_bit2);
        if (!pwm) begin
            if (match && ch.kind != tcom_pkg::TCOM_RSVD) begin
                unique case (ch.code)
                    `TCOM_CODE_OFF: wave_next = wave_reg;
                    `TCOM_CODE_TOGGLE: wave_next = !wave_reg;
                    `TCOM_CODE_CLEAR: wave_next = 1'b0;
                    `TCOM_CODE_SET: wave_next = 1'b1;
                endcase
            end
        end else if (ch.code == `TCOM_CODE_TOGGLE) begin
            // channel b code 01 is reserved in pwm: output simply holds
            if (IS_A && ch.mode_bit2 && match) begin
                wave_next = !wave_reg;
            end
        end else if (ch.code[1]) begin
            // compare equal to top: the match is dropped, only the top action runs
            if (at_top && (fast || cmp_is_top)) begin
                wave_next = ch.code == `TCOM_CODE_CLEAR;
            end else if (match && !cmp_is_top) begin
                wave_next = (fast || !ch.down) ? (ch.code == `TCOM_CODE_SET)
                                               : (ch.code == `TCOM_CODE_CLEAR);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wave_reg <= 1'b0;
            conn_reg <= 1'b0;
        end else begin
            wave_reg <= wave_next;
            conn_reg <= conn_next;
        end
    end

    assign ch.wave = wave_reg;
    assign ch.conn = conn_reg;
endmodule
`default_nettype wire

// ===== logic/tcom_axil_slave.sv
`include "tcom_params.svh"
`default_nettype none
module tcom_axil_slave (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic s_axil_awvalid,
    output logic s_axil_awready,
    input wire logic [7:0] s_axil_awaddr,
    input wire logic s_axil_wvalid,
    output logic s_axil_wready,
    input wire logic [31:0] s_axil_wdata,
    input wire logic [3:0] s_axil_wstrb,
    output logic s_axil_bvalid,
    input wire logic s_axil_bready,
    output logic [1:0] s_axil_bresp,
    input wire logic s_axil_arvalid,
    output logic s_axil_arready,
    input wire logic [7:0] s_axil_araddr,
    output logic s_axil_rvalid,
    input wire logic s_axil_rready,
    output logic [31:0] s_axil_rdata,
    output logic [1:0] s_axil_rresp,
    tcom_reg_if.slave rg
);
    logic aw_have_reg, aw_have_next, w_have_reg, w_have_next, w_en_reg, w_en_next;
    logic [5:0] aw_idx_reg, aw_idx_next;
    logic [7:0] w_data_reg, w_data_next, rdata_reg, rdata_next;
    logic awready_reg, awready_next, wready_reg, wready_next, bvalid_reg, bvalid_next;
    logic arready_reg, arready_next, rvalid_reg, rvalid_next, commit;
    logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;

    always_comb begin
        commit = aw_have_reg && w_have_reg && !bvalid_reg;
        aw_have_next = aw_have_reg;
        aw_idx_next = aw_idx_reg;
        w_have_next = w_have_reg;
        w_data_next = w_data_reg;
        w_en_next = w_en_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        if (s_axil_awvalid && awready_reg) begin
            aw_have_next = 1'b1;
            aw_idx_next = s_axil_awaddr[7:2];
        end
        if (s_axil_wvalid && wready_reg) begin
            w_have_next = 1'b1;
            w_data_next = s_axil_wdata[7:0];
            w_en_next = s_axil_wstrb[0];
        end
        if (commit) begin
            aw_have_next = 1'b0;
            w_have_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = rg.wr_hit ? `TCOM_RESP_OKAY : `TCOM_RESP_SLVERR;
        end else if (bvalid_reg && s_axil_bready) begin
            bvalid_next = 1'b0;
        end
        awready_next = !aw_have_next && !bvalid_next;
        wready_next = !w_have_next && !bvalid_next;
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        if (s_axil_arvalid && arready_reg) begin
            rvalid_next = 1'b1;
            rdata_next = rg.rd_hit ? rg.rd_data : 8'h00;
            rresp_next = rg.rd_hit ? `TCOM_RESP_OKAY : `TCOM_RESP_SLVERR;
        end else if (rvalid_reg && s_axil_rready) begin
            rvalid_next = 1'b0;
        end
        arready_next = !rvalid_next;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_have_reg <= 1'b0;
            aw_idx_reg <= 6'h00;
            w_have_reg <= 1'b0;
            w_data_reg <= 8'h00;
            w_en_reg <= 1'b0;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= 2'h0;
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= 8'h00;
            rresp_reg <= 2'h0;
        end else begin
            aw_have_reg <= aw_have_next;
            aw_idx_reg <= aw_idx_next;
            w_have_reg <= w_have_next;
            w_data_reg <= w_data_next;
            w_en_reg <= w_en_next;
            awready_reg <= awready_next;
            wready_reg <= wready_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            arready_reg <= arready_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
        end
    end

    assign rg.wr_en = commit && w_en_reg;
    assign rg.wr_idx = aw_idx_reg;
    assign rg.wr_data = w_data_reg;
    assign rg.rd_idx = s_axil_araddr[7:2];
    assign s_axil_awready = awready_reg;
    assign s_axil_wready = wready_reg;
    assign s_axil_bvalid = bvalid_reg;
    assign s_axil_bresp = bresp_reg;
    assign s_axil_arready = arready_reg;
    assign s_axil_rvalid = rvalid_reg;
    assign s_axil_rdata = {24'h000000, rdata_reg};
    assign s_axil_rresp = rresp_reg;
endmodule
`default_nettype wire

// ===== logic/tcom_top.sv
// Behaviour
// - a nonzero output-mode field hands the channel's pin to its waveform output, except pwm channel a code 01 with third mode bit 0
// - non-pwm channel a: 00 off, 01 toggle, 10 clear, 11 set on match
// - non-pwm channel b: 00 off, 01 toggle, 10 clear, 11 set on match
// - pwm channel a code 01: released when third mode bit 0, toggles when 1
// - fast pwm channel a: 10 clears on match, sets at top; 11 inverse
// - fast pwm channel b: 01 reserved; 10 clear on match, set at top; 11 inverse
// - phase pwm channel a: 10 clears on up match, sets on down; 11 inverse
// - phase pwm channel b: 01 reserved; 10 clear up, set down; 11 inverse
// - pwm channel a, compare equal to top, high bit set: only top action
// - pwm channel b, compare equal to top, high bit set: only top action
// - control bits 3:2 read zero; whole control register resets to zero
// - three mode bits pick normal, phase pwm, clear-on-match, fast pwm or reserved
//
// The AXI4-Lite interface to the registers is this design's own decision.
`include "tcom_params.svh"
`default_nettype none
module tcom_top (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic s_axil_awvalid,
    output logic s_axil_awready,
    input wire logic [7:0] s_axil_awaddr,
    input wire logic s_axil_wvalid,
    output logic s_axil_wready,
    input wire logic [31:0] s_axil_wdata,
    input wire logic [3:0] s_axil_wstrb,
    output logic s_axil_bvalid,
    input wire logic s_axil_bready,
    output logic [1:0] s_axil_bresp,
    input wire logic s_axil_arvalid,
    output logic s_axil_arready,
    input wire logic [7:0] s_axil_araddr,
    output logic s_axil_rvalid,
    input wire logic s_axil_rready,
    output logic [31:0] s_axil_rdata,
    output logic [1:0] s_axil_rresp,
    input wire logic [7:0] timer_count_value,
    input wire logic timer_tick,
    input wire logic timer_count_down,
    output logic chan_a_wave_out,
    output logic chan_b_wave_out,
    output logic chan_a_pin_override,
    output logic chan_b_pin_override
);
    logic [1:0] chan_a_output_mode_reg, chan_a_output_mode_next;
    logic [1:0] chan_b_output_mode_reg, chan_b_output_mode_next;
    logic [1:0] wave_low_reg, wave_low_next;
    logic waveform_mode_bit2_reg, waveform_mode_bit2_next;
    logic [7:0] chan_a_compare_value_reg, chan_a_compare_value_next;
    logic [7:0] chan_b_compare_value_reg, chan_b_compare_value_next;
    logic [7:0] ctrl_a_view, status_view;
    tcom_pkg::tcom_wave_t kind;
    logic [7:0] top_value;

    tcom_reg_if reg_bus();
    tcom_chan_if chan_bus[2]();

    tcom_axil_slave u_slave (
        .clk(clk),
        .rst_n(rst_n),
        .s_axil_awvalid(s_axil_awvalid),
        .s_axil_awready(s_axil_awready),
        .s_axil_awaddr(s_axil_awaddr),
        .s_axil_wvalid(s_axil_wvalid),
        .s_axil_wready(s_axil_wready),
        .s_axil_wdata(s_axil_wdata),
        .s_axil_wstrb(s_axil_wstrb),
        .s_axil_bvalid(s_axil_bvalid),
        .s_axil_bready(s_axil_bready),
        .s_axil_bresp(s_axil_bresp),
        .s_axil_arvalid(s_axil_arvalid),
        .s_axil_arready(s_axil_arready),
        .s_axil_araddr(s_axil_araddr),
        .s_axil_rvalid(s_axil_rvalid),
        .s_axil_rready(s_axil_rready),
        .s_axil_rdata(s_axil_rdata),
        .s_axil_rresp(s_axil_rresp),
        .rg(reg_bus.slave)
    );

    // register file: written fields steer the channels from the following cycle
    always_comb begin
        chan_a_output_mode_next = chan_a_output_mode_reg;
        chan_b_output_mode_next = chan_b_output_mode_reg;
        wave_low_next = wave_low_reg;
        waveform_mode_bit2_next = waveform_mode_bit2_reg;
        chan_a_compare_value_next = chan_a_compare_value_reg;
        chan_b_compare_value_next = chan_b_compare_value_reg;
        if (reg_bus.wr_en) begin
            unique case (reg_bus.wr_idx)
                `TCOM_CTRL_A_IDX: begin
                    chan_a_output_mode_next = reg_bus.wr_data[7:6];
                    chan_b_output_mode_next = reg_bus.wr_data[5:4];
                    wave_low_next = reg_bus.wr_data[1:0];
                end
                `TCOM_MODE_HI_IDX: waveform_mode_bit2_next = reg_bus.wr_data[0];
                `TCOM_CMP_A_IDX: chan_a_compare_value_next = reg_bus.wr_data;
                `TCOM_CMP_B_IDX: chan_b_compare_value_next = reg_bus.wr_data;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            chan_a_output_mode_reg <= 2'h0;
            chan_b_output_mode_reg <= 2'h0;
            wave_low_reg <= 2'h0;
            waveform_mode_bit2_reg <= 1'b0;
            chan_a_compare_value_reg <= 8'h00;
            chan_b_compare_value_reg <= 8'h00;
        end else begin
            chan_a_output_mode_reg <= chan_a_output_mode_next;
            chan_b_output_mode_reg <= chan_b_output_mode_next;
            wave_low_reg <= wave_low_next;
            waveform_mode_bit2_reg <= waveform_mode_bit2_next;
            chan_a_compare_value_reg <= chan_a_compare_value_next;
            chan_b_compare_value_reg <= chan_b_compare_value_next;
        end
    end

    // reads are taken in the address cycle, so the mux is purely combinational
    always_comb begin
        ctrl_a_view = {chan_a_output_mode_reg, chan_b_output_mode_reg, 2'b00, wave_low_reg};
        status_view = {4'h0, chan_bus[1].conn, chan_bus[0].conn, chan_bus[1].wave,
                       chan_bus[0].wave};
        reg_bus.rd_hit = 1'b1;
        unique case (reg_bus.rd_idx)
            `TCOM_CTRL_A_IDX: reg_bus.rd_data = ctrl_a_view;
            `TCOM_MODE_HI_IDX: reg_bus.rd_data = {7'h00, waveform_mode_bit2_reg};
            `TCOM_CMP_A_IDX: reg_bus.rd_data = chan_a_compare_value_reg;
            `TCOM_CMP_B_IDX: reg_bus.rd_data = chan_b_compare_value_reg;
            `TCOM_STATUS_IDX: reg_bus.rd_data = status_view;
            default: begin
                reg_bus.rd_data = 8'h00;
                reg_bus.rd_hit = 1'b0;
            end
        endcase
    end

    // status is read-only: a write there is accepted and dropped
    assign reg_bus.wr_hit = (reg_bus.wr_idx == `TCOM_CTRL_A_IDX) ||
                            (reg_bus.wr_idx == `TCOM_MODE_HI_IDX) ||
                            (reg_bus.wr_idx == `TCOM_CMP_A_IDX) ||
                            (reg_bus.wr_idx == `TCOM_CMP_B_IDX) ||
                            (reg_bus.wr_idx == `TCOM_STATUS_IDX);

    always_comb begin
        kind = tcom_pkg::tcom_decode({waveform_mode_bit2_reg, wave_low_reg});
        // ctc and the compare-topped pwm modes share channel a's compare as top
        top_value = (kind == tcom_pkg::TCOM_CTC || kind == tcom_pkg::TCOM_PHASE_CMP ||
                     kind == tcom_pkg::TCOM_FAST_CMP) ? chan_a_compare_value_reg
                                                      : `TCOM_MAX;
    end

    for (genvar g = 0; g < 2; g++) begin : g_chan
        logic match, at_top, fast, phase, pwm, cmp_is_top;

        assign chan_bus[g].code = (g == 0) ? chan_a_output_mode_reg : chan_b_output_mode_reg;
        assign chan_bus[g].kind = kind;
        assign chan_bus[g].mode_bit2 = waveform_mode_bit2_reg;
        assign chan_bus[g].cmp = (g == 0) ? chan_a_compare_value_reg : chan_b_compare_value_reg;
        assign chan_bus[g].top = top_value;
        assign chan_bus[g].count = timer_count_value;
        assign chan_bus[g].tick = timer_tick;
        assign chan_bus[g].down = timer_count_down;

        tcom_wave_chan #(
            .IS_A(g == 0)
        ) u_chan (
            .clk(clk),
            .rst_n(rst_n),
            .ch(chan_bus[g].chan)
        );

        assign match = timer_tick && (timer_count_value == chan_bus[g].cmp);
        assign at_top = timer_tick && (timer_count_value == top_value);
        assign fast = (kind == tcom_pkg::TCOM_FAST_MAX) || (kind == tcom_pkg::TCOM_FAST_CMP);
        assign phase = (kind == tcom_pkg::TCOM_PHASE_MAX) || (kind == tcom_pkg::TCOM_PHASE_CMP);
        assign pwm = fast || phase;
        assign cmp_is_top = chan_bus[g].cmp == top_value;

        a_pin_override: assert property (@(posedge clk) disable iff (!rst_n)
            (!pwm && chan_bus[g].code != 2'h0) |=> chan_bus[g].conn)
            else $error("nonzero mode field did not take the pin");
        a_pin_released: assert property (@(posedge clk) disable iff (!rst_n)
            (chan_bus[g].code == 2'h0) |=> !chan_bus[g].conn)
            else $error("pin kept with mode field zero");
        a_nonpwm_toggle: assert property (@(posedge clk) disable iff (!rst_n)
            (kind == tcom_pkg::TCOM_NORMAL && chan_bus[g].code == 2'h1 && match)
            |=> (chan_bus[g].wave != $past(chan_bus[g].wave)))
            else $error("toggle on match missing");
        a_nonpwm_clear: assert property (@(posedge clk) disable iff (!rst_n)
            (kind == tcom_pkg::TCOM_CTC && chan_bus[g].code == 2'h2 && match)
            |=> !chan_bus[g].wave)
            else $error("clear on match missing");
        a_nonpwm_set: assert property (@(posedge clk) disable iff (!rst_n)
            (!pwm && kind != tcom_pkg::TCOM_RSVD && chan_bus[g].code == 2'h3 && match)
            |=> chan_bus[g].wave)
            else $error("set on match missing");
        a_fast_at_top: assert property (@(posedge clk) disable iff (!rst_n)
            (fast && chan_bus[g].code == 2'h2 && at_top) |=> chan_bus[g].wave)
            else $error("fast pwm top did not set output");
        a_fast_match: assert property (@(posedge clk) disable iff (!rst_n)
            (fast && chan_bus[g].code == 2'h3 && match && !cmp_is_top)
            ##1 (!timer_tick) [*2] |-> chan_bus[g].wave)
            else $error("inverted fast pwm match did not set output");
        a_phase_up: assert property (@(posedge clk) disable iff (!rst_n)
            (phase && chan_bus[g].code == 2'h2 && match && !cmp_is_top && !timer_count_down)
            |=> !chan_bus[g].wave)
            else $error("phase pwm up match did not clear");
        a_phase_down: assert property (@(posedge clk) disable iff (!rst_n)
            (phase && chan_bus[g].code == 2'h2 && match && !cmp_is_top && timer_count_down)
            |=> chan_bus[g].wave)
            else $error("phase pwm down match did not set");
        a_top_ignore: assert property (@(posedge clk) disable iff (!rst_n)
            (pwm && chan_bus[g].code == 2'h3 && cmp_is_top && at_top) |=> !chan_bus[g].wave)
            else $error("match at top not ignored");

        if (g == 0) begin : g_a
            a_a_toggle_off: assert property (@(posedge clk) disable iff (!rst_n)
                (pwm && chan_bus[0].code == 2'h1 && !waveform_mode_bit2_reg)
                |=> !chan_bus[0].conn)
                else $error("channel a toggle kept pin without third bit");
            a_a_toggle_on: assert property (@(posedge clk) disable iff (!rst_n)
                (pwm && chan_bus[0].code == 2'h1 && waveform_mode_bit2_reg && match)
                |=> (chan_bus[0].wave != $past(chan_bus[0].wave)) && chan_bus[0].conn)
                else $error("channel a pwm toggle missing");
        end else begin : g_b
            a_b_reserved: assert property (@(posedge clk) disable iff (!rst_n)
                (pwm && chan_bus[1].code == 2'h1) |=> $stable(chan_bus[1].wave))
                else $error("reserved channel b code moved output");
        end
    end

    a_rsvd_read_zero: assert property (@(posedge clk) disable iff (!rst_n)
        (s_axil_arvalid && s_axil_arready && s_axil_araddr[7:2] == `TCOM_CTRL_A_IDX)
        |=> s_axil_rvalid && (s_axil_rdata[3:2] == 2'b00))
        else $error("reserved control bits read nonzero");
    a_write_applies: assert property (@(posedge clk) disable iff (!rst_n)
        (reg_bus.wr_en && reg_bus.wr_idx == `TCOM_CTRL_A_IDX)
        |=> ((ctrl_a_view ^ $past(reg_bus.wr_data)) & 8'hf3) == 8'h00)
        else $error("control write not applied next cycle");
    a_top_from_cmp: assert property (@(posedge clk) disable iff (!rst_n)
        (waveform_mode_bit2_reg && wave_low_reg == 2'h1) |-> top_value == chan_a_compare_value_reg)
        else $error("phase pwm mode 5 top is not compare a");
    a_top_is_max: assert property (@(posedge clk) disable iff (!rst_n)
        (!waveform_mode_bit2_reg && wave_low_reg[0]) |-> top_value == `TCOM_MAX)
        else $error("mode 1 or 3 top is not max");

    assign chan_a_wave_out = chan_bus[0].wave;
    assign chan_b_wave_out = chan_bus[1].wave;
    assign chan_a_pin_override = chan_bus[0].conn;
    assign chan_b_pin_override = chan_bus[1].conn;
endmodule
`default_nettype wire

// ===== sim/tcom_pin_model.sv
`default_nettype none
module tcom_pin_model (
    input wire logic dir_out,
    input wire logic port_out,
    input wire logic pin_override,
    input wire logic wave,
    output logic pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // pull-up holds the pin high while its output driver is off
    assign pin = !dir_out ? 1'b1 : (pin_override ? wave : port_out);
endmodule
`default_nettype wire

// ===== sim/tb.sv
`include "tcom_params.svh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst_n = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0, tick = 0, dn = 0;
    logic [7:0] awaddr = 0, araddr = 0, cnt = 0;
    logic [31:0] wdata = 0, rdata, rd;
    logic awr, wr_rdy, bv, arr, rv, wa, wb, oa, ob, pin_a;
    logic [1:0] bresp, rresp, resp;
    logic [1:0] codes [4] = '{2'h2, 2'h3, 2'h1, 2'h1};
    logic ex [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
    logic eb = 1'b0, dir_a = 1'b1;
    int fail_count = 0, checked = 0;
    tcom_top dut (.clk(clk), .rst_n(rst_n), .s_axil_awvalid(awv), .s_axil_awready(awr),
        .s_axil_awaddr(awaddr), .s_axil_wvalid(wv), .s_axil_wready(wr_rdy), .s_axil_wdata(wdata),
        .s_axil_wstrb(4'h1), .s_axil_bvalid(bv), .s_axil_bready(bready), .s_axil_bresp(bresp),
        .s_axil_arvalid(arv), .s_axil_arready(arr), .s_axil_araddr(araddr), .s_axil_rvalid(rv),
        .s_axil_rready(rready), .s_axil_rdata(rdata), .s_axil_rresp(rresp),
        .timer_count_value(cnt), .timer_tick(tick), .timer_count_down(dn),
        .chan_a_wave_out(wa), .chan_b_wave_out(wb), .chan_a_pin_override(oa),
        .chan_b_pin_override(ob));
    tcom_pin_model pin_a_model (.dir_out(dir_a), .port_out(1'b0), .pin_override(oa), .wave(wa),
        .pin(pin_a));
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        awv <= 1'b1;
        wv <= 1'b1;
        awaddr <= a;
        wdata <= {24'h0, d};
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awv && awr === 1'b1) awv <= 1'b0;
            if (wv && wr_rdy === 1'b1) wv <= 1'b0;
        end while (bv !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
    endtask
    task automatic rdr(input logic [7:0] a);
        @(posedge clk);
        arv <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arv && arr === 1'b1) arv <= 1'b0;
        end while (rv !== 1'b1);
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask
    // one counter event, then both waveform outputs compared once settled
    task automatic tk(input logic [7:0] c, input logic d, input logic ea, input logic e_b);
        @(posedge clk);
        cnt <= c;
        dn <= d;
        tick <= 1'b1;
        @(posedge clk);
        tick <= 1'b0;
        @(negedge clk);
        chk({30'h0, wa, wb}, {30'h0, ea, e_b});
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        summarize();
    end
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rdr(8'hbc);
        chk(rd, 32'h0);
        wr(8'hbc, 8'hff);
        chk({30'h0, resp}, {30'h0, `TCOM_RESP_OKAY});
        rdr(8'hbc);
        chk(rd, 32'hf3);
        rdr(8'h00);
        chk({30'h0, resp}, {30'h0, `TCOM_RESP_SLVERR});
        wr(8'h00, 8'h55);
        chk({30'h0, resp}, {30'h0, `TCOM_RESP_SLVERR});
        wr(8'hc4, 8'h10);
        wr(8'hc8, 8'h20);
        for (int i = 0; i < 4; i++) begin
            wr(8'hbc, {codes[i], codes[i], 4'h0});
            tk(8'h10, 1'b0, ex[i], eb);
            tk(8'h20, 1'b0, ex[i], ex[i]);
            eb = ex[i];
            chk({29'h0, oa, ob, pin_a}, {29'h0, 2'h3, ex[i]});
        end
        wr(8'hbc, 8'ha3);
        tk(8'h10, 1'b0, 1'b0, 1'b1);
        tk(8'hff, 1'b0, 1'b1, 1'b1);
        tk(8'h20, 1'b0, 1'b1, 1'b0);
        tk(8'hff, 1'b0, 1'b1, 1'b1);
        wr(8'hbc, 8'ha1);
        tk(8'h10, 1'b0, 1'b0, 1'b1);
        tk(8'h20, 1'b0, 1'b0, 1'b0);
        tk(8'h20, 1'b1, 1'b0, 1'b1);
        tk(8'h10, 1'b1, 1'b1, 1'b1);
        wr(8'hc4, 8'hff);
        wr(8'hc8, 8'hff);
        wr(8'hbc, 8'he3);
        tk(8'hff, 1'b0, 1'b0, 1'b1);
        wr(8'hbc, 8'h63);
        repeat (3) @(negedge clk);
        chk({30'h0, oa, ob}, {30'h0, 2'h1});
        wr(8'hc0, 8'h01);
        tk(8'hff, 1'b0, 1'b1, 1'b1);
        // mode 5: channel a toggles, reserved channel b code holds its output
        wr(8'hbc, 8'h51);
        tk(8'hff, 1'b0, 1'b0, 1'b1);
        wr(8'hc0, 8'h00);
        wr(8'hbc, 8'ha2);
        tk(8'hff, 1'b0, 1'b0, 1'b0);
        // inverted fast match below top, followed by one idle counter cycle before the bench ends
        wr(8'hc8, 8'h20);
        wr(8'hbc, 8'hf3);
        tk(8'h20, 1'b0, 1'b0, 1'b1);
        @(posedge clk);
        dir_a <= 1'b0;
        @(negedge clk);
        chk({31'h0, pin_a}, 32'h1);
        summarize();
    end
endmodule
`default_nettype wire
